// >>> vsc_regs.vh
// Constants for the slot-zero role and configuration loader
`ifndef VSC_REGS_VH
`define VSC_REGS_VH
`define VSC_ROLE_AUTO 2'h0
`define VSC_ROLE_NONSC 2'h1
`define VSC_ROLE_SC 2'h2
`define VSC_CLK_HZ 100000000
`define VSC_SYSCLK_HZ 16000000
`define VSC_CLK10_HZ 10000000
`define VSC_SYSCLK_HALF (`VSC_CLK_HZ / (2 * `VSC_SYSCLK_HZ))
`define VSC_CLK10_HALF (`VSC_CLK_HZ / (2 * `VSC_CLK10_HZ))
`define VSC_RM_READY_MS 5000
`define VSC_CMOS_CLR_MS 1000
`define VSC_MS_CYC (`VSC_CLK_HZ / 1000)
`define VSC_NWORDS 16
`define VSC_AW 5
`define VSC_HALF_FACTORY 1'b0
`define VSC_HALF_USER 1'b1
`define VSC_REG_ADDR 4'h0
`define VSC_REG_ROLE 4'h1
`define VSC_REG_CLKSRC 4'h2
`define VSC_REG_CFGSTAT 4'h3
`endif

// >>> vsc_mem.v
// Two-half default store of interface register values
`timescale 1ns/1ps
module vsc_mem (
    mclk,
    rst_n,
    ce,
    wr_en,
    wr_addr,
    wr_data,
    rd_addr,
    rd_data
);
    input wire mclk;
    input wire rst_n;
    input wire ce;
    input wire wr_en;
    input wire [4:0] wr_addr;
    input wire [15:0] wr_data;
    input wire [4:0] rd_addr;
    output reg [15:0] rd_data;
    reg [15:0] mem [0:31];
    always @(posedge mclk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
        end else if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // vsc_mem

// >>> vsc_top.v
// Slot-zero role selection, system clocks, arbiter and power-up load
`timescale 1ns/1ps
`include "vsc_regs.vh"
module vsc_top #(
    parameter RM_READY_CYC = `VSC_RM_READY_MS * `VSC_MS_CYC,
    parameter CMOS_CLR_CYC = `VSC_CMOS_CLR_MS * `VSC_MS_CYC
) (
    input wire mclk,
    input wire rst_n,
    input wire ce,
    input wire [1:0] role_sel,
    input wire slot0_detect,
    input wire power_on_self_config,
    input wire user_half_sel,
    input wire ext_clk_sel,
    input wire clk10_route_en,
    input wire term50_en,
    input wire cmos_clear_sel,
    input wire sysrst_n,
    input wire [3:0] bus_req,
    output reg [3:0] bus_grant,
    output reg sysclk_out,
    output wire sysclk_oe,
    input wire clk10_in,
    input wire ext_clk_in,
    output reg clk10_out,
    output wire clk10_oe,
    output reg external_clock_connector,
    output wire ext_clk_conn_oe,
    output wire ext_term_on,
    output reg cmos_clear,
    output reg is_sys_ctrl,
    output reg cfg_done,
    output reg vxi_ready,
    output reg rm_timeout,
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    output reg [3:0] host_cfg,
    output reg [11:0] bp_cfg,
    input wire mem_wr,
    input wire [4:0] mem_waddr,
    input wire [15:0] mem_wdata
);
    localparam S_IDLE = 2'h0;
    localparam S_READ = 2'h1;
    localparam S_DONE = 2'h2;
    localparam S_OFF = 2'h3;
    // Divider end counts and last load index
    localparam integer SYS_LAST = `VSC_SYSCLK_HALF - 1;
    localparam integer C10_LAST = `VSC_CLK10_HALF - 1;
    localparam integer LOAD_LAST = `VSC_NWORDS - 1;
    // Divider wrap test, shared by both clocks
    function div_wrap;
        input [7:0] cnt;
        input integer last;
        begin
            div_wrap = (cnt == last[7:0]);
        end
    endfunction
    // Fixed-priority pick, level 3 highest
    function [3:0] prio_grant;
        input [3:0] r;
        begin
            if (r[3]) begin
                prio_grant = 4'h8;
            end else if (r[2]) begin
                prio_grant = 4'h4;
            end else if (r[1]) begin
                prio_grant = 4'h2;
            end else if (r[0]) begin
                prio_grant = 4'h1;
            end else begin
                prio_grant = 4'h0;
            end
        end
    endfunction
    // Two-flop synchronisers for pins
    reg [10:0] s1_q, s2_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 11'h000;
            s2_q <= 11'h000;
        end else if (ce) begin
            s1_q <= {clk10_in, ext_clk_in, cmos_clear_sel, sysrst_n, slot0_detect, bus_req,
                     role_sel};
            s2_q <= s1_q;
        end
    end
    wire [1:0] role_s = s2_q[1:0];
    wire [3:0] req_s = s2_q[5:2];
    wire slot0_s = s2_q[6];
    wire sysrst_s = s2_q[7];
    wire clr_s = s2_q[8];
    wire ext_s = s2_q[9];
    wire c10_s = s2_q[10];
    reg [3:0] strap_sync1_q, strap_sync2_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            strap_sync1_q <= 4'h0;
            strap_sync2_q <= 4'h0;
        end else if (ce) begin
            strap_sync1_q <= {clk10_route_en, term50_en, ext_clk_sel, user_half_sel};
            strap_sync2_q <= strap_sync1_q;
        end
    end
    // Straps caught once after reset release
    reg latched_q;
    reg [1:0] role_q;
    reg half_q, ext_sel_q, power_on_self_config_q, slot0_q;
    reg [1:0] lat_cnt_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latched_q <= 1'b0;
            lat_cnt_q <= 2'h0;
            role_q <= `VSC_ROLE_AUTO;
            half_q <= `VSC_HALF_USER;
            ext_sel_q <= 1'b0;
            power_on_self_config_q <= 1'b1;
            slot0_q <= 1'b0;
        end else if (ce && !latched_q) begin
            lat_cnt_q <= lat_cnt_q + 2'h1;
            if (lat_cnt_q == 2'h3) begin
                latched_q <= 1'b1;
                role_q <= role_s;
                half_q <= strap_sync2_q[0];
                ext_sel_q <= strap_sync2_q[1];
                power_on_self_config_q <= power_on_self_config;
                slot0_q <= slot0_s;
            end
        end
    end
    function is_sc;
        input [1:0] r;
        input s0;
        begin
            if (r == `VSC_ROLE_SC) begin
                is_sc = 1'b1;
            end else if (r == `VSC_ROLE_NONSC) begin
                is_sc = 1'b0;
            end else begin
                is_sc = s0;
            end
        end
    endfunction
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            is_sys_ctrl <= 1'b0;
        end else if (ce) begin
            is_sys_ctrl <= latched_q & is_sc(role_q, slot0_q);
        end
    end
    // Fixed-priority arbiter, level 3 highest
    reg [3:0] grant_d;
    always @* begin
        grant_d = prio_grant(req_s);
    end
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_grant <= 4'h0;
        end else if (ce) begin
            if (!is_sys_ctrl) begin
                bus_grant <= 4'h0;
            end else if ((bus_grant & req_s) == 4'h0) begin
                bus_grant <= grant_d;
            end
        end
    end
    // Clock dividers
    reg [7:0] sys_cnt_q, c10_cnt_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sys_cnt_q <= 8'h00;
            sysclk_out <= 1'b0;
            c10_cnt_q <= 8'h00;
            clk10_out <= 1'b0;
            external_clock_connector <= 1'b0;
        end else if (ce) begin
            if (div_wrap(sys_cnt_q, SYS_LAST)) begin
                sys_cnt_q <= 8'h00;
                sysclk_out <= ~sysclk_out;
            end else begin
                sys_cnt_q <= sys_cnt_q + 8'h01;
            end
            if (ext_sel_q) begin
                clk10_out <= ext_s;
            end else if (div_wrap(c10_cnt_q, C10_LAST)) begin
                c10_cnt_q <= 8'h00;
                clk10_out <= ~clk10_out;
            end else begin
                c10_cnt_q <= c10_cnt_q + 8'h01;
            end
            external_clock_connector <= is_sys_ctrl ? clk10_out : c10_s;
        end
    end
    assign sysclk_oe = is_sys_ctrl;
    assign clk10_oe = is_sys_ctrl;
    assign ext_clk_conn_oe = strap_sync2_q[3] & ~(is_sys_ctrl & ext_sel_q);
    assign ext_term_on = strap_sync2_q[2] & ext_sel_q;
    // Setup memory clear after hold time
    reg [31:0] clr_cnt_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clr_cnt_q <= 32'h0;
            cmos_clear <= 1'b0;
        end else if (ce) begin
            if (!clr_s) begin
                clr_cnt_q <= 32'h0;
                cmos_clear <= 1'b0;
            end else if (clr_cnt_q >= CMOS_CLR_CYC[31:0] - 32'h1) begin
                cmos_clear <= 1'b1;
            end else begin
                clr_cnt_q <= clr_cnt_q + 32'h1;
            end
        end
    end
    // Power-up load sequencer
    reg [1:0] st_q;
    reg [4:0] idx_q;
    reg rd_pend_q;
    wire [15:0] mem_rd;
    wire [4:0] rd_addr = {half_q, idx_q[3:0]};
    vsc_mem u_mem (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .wr_en(mem_wr),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_addr(rd_addr),
        .rd_data(mem_rd)
    );
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
            idx_q <= 5'h00;
            rd_pend_q <= 1'b0;
            cfg_done <= 1'b0;
            host_cfg <= 4'h0;
            bp_cfg <= 12'h000;
        end else if (ce) begin
            case (st_q)
                S_IDLE: begin
                    if (latched_q) begin
                        st_q <= power_on_self_config_q ? S_READ : S_OFF;
                        idx_q <= 5'h00;
                    end
                end
                S_READ: begin
                    rd_pend_q <= 1'b1;
                    if (rd_pend_q) begin
                        if (idx_q == 5'h01) begin
                            host_cfg <= mem_rd[3:0];
                            bp_cfg <= mem_rd[15:4];
                        end
                        idx_q <= idx_q + 5'h01;
                        rd_pend_q <= 1'b0;
                        if (idx_q == LOAD_LAST[4:0]) begin
                            st_q <= S_DONE;
                            cfg_done <= 1'b1;
                        end
                    end
                end
                S_DONE: begin
                    st_q <= S_DONE;
                end
                default: begin
                    st_q <= S_OFF;
                end
            endcase
        end
    end
    // Readiness and 5 s deadline after backplane reset release
    reg [31:0] rm_cnt_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rm_cnt_q <= 32'h0;
            vxi_ready <= 1'b0;
            rm_timeout <= 1'b0;
        end else if (ce) begin
            vxi_ready <= cfg_done & sysrst_s;
            if (!sysrst_s) begin
                rm_cnt_q <= 32'h0;
            end else if (!cfg_done && rm_cnt_q < RM_READY_CYC[31:0]) begin
                rm_cnt_q <= rm_cnt_q + 32'h1;
            end else if (!cfg_done) begin
                rm_timeout <= 1'b1;
            end
        end
    end
    // Register port
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else if (ce) begin
            if (rd && addr == `VSC_REG_ROLE) begin
                rdata <= {13'h0, is_sys_ctrl, role_q};
            end else if (rd && addr == `VSC_REG_CLKSRC) begin
                rdata <= {13'h0, ext_term_on, strap_sync2_q[3], ext_sel_q};
            end else if (rd && addr == `VSC_REG_CFGSTAT) begin
                rdata <= {11'h0, rm_timeout, vxi_ready, cfg_done, half_q, power_on_self_config_q};
            end else if (rd && addr == `VSC_REG_ADDR) begin
                rdata <= {4'h0, bp_cfg};
            end else begin
                rdata <= 16'h0000;
            end
        end
    end
    wire unused_w = wr ^ wdata[0];
endmodule // vsc_top

// >>> vsc_far.sv
// Far-side model: bus requesters and clock sources
`timescale 1ns/1ps
module vsc_far (
    input wire mclk,
    input wire rst_n,
    input wire [3:0] req_set,
    input wire [3:0] bus_grant,
    output logic [3:0] bus_req,
    output logic ext_clk_in,
    output logic clk10_in
);
    int hold[4];
    initial begin
        ext_clk_in = 0;
        clk10_in = 0;
        #3;
        fork
            forever #80 ext_clk_in = ~ext_clk_in;
            forever #50 clk10_in = ~clk10_in;
        join
    end
    // Request held until served for four cycles
    always @(posedge mclk or negedge rst_n) begin
        for (int i = 0; i < 4; i++) begin
            hold[i] <= bus_grant[i] ? hold[i] + 1 : 0;
            if (!rst_n)
                bus_req[i] <= 1'b0;
            else if (req_set[i])
                bus_req[i] <= 1'b1;
            else if (hold[i] == 3)
                bus_req[i] <= 1'b0;
        end
    end
endmodule // vsc_far

// >>> vsc_top_assertions.sv
// Checker for the slot-zero role and load block
`timescale 1ns/1ps
module vsc_chk #(parameter CMOS_CLR_CYC = 50) (
    input wire mclk,
    input wire rst_n,
    input wire [3:0] bus_grant,
    input wire is_sys_ctrl,
    input wire sysclk_out,
    input wire clk10_oe,
    input wire ext_term_on,
    input wire term50_en,
    input wire cmos_clear,
    input wire cmos_clear_sel,
    input wire rd,
    input wire [3:0] addr,
    input wire [15:0] rdata,
    input wire cfg_done,
    input wire vxi_ready
);
    int sel_cnt;
    int up_cnt;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_cnt <= 0;
            up_cnt <= 0;
        end else begin
            sel_cnt <= cmos_clear_sel ? sel_cnt + 1 : 0;
            up_cnt <= (up_cnt < 20) ? up_cnt + 1 : up_cnt;
        end
    end
    grant_onehot_a: assert property ($onehot0(bus_grant)) else $error("grant not one-hot");
    grant_role_a: assert property (bus_grant != 4'h0 |-> is_sys_ctrl) else $error("grant off role");
    sysclk_half_a: assert property (is_sys_ctrl && $changed(sysclk_out) |=>
        $stable(sysclk_out)[*2] ##1 $changed(sysclk_out)) else $error("sysclk half period");
    clk10_oe_a: assert property (clk10_oe |-> is_sys_ctrl) else $error("clk10 driven off slot0");
    term_gate_a: assert property (ext_term_on |-> $past(term50_en, 2)) else $error("termination unasked");
    clear_hold_a: assert property ($rose(cmos_clear) |-> sel_cnt >= CMOS_CLR_CYC - 4)
        else $error("clear too early");
    clear_release_a: assert property (!cmos_clear_sel [*4] |=> !cmos_clear) else $error("clear stuck");
    status_read_a: assert property (rd && addr == 4'h3 |=>
        rdata[3:2] == $past({vxi_ready, cfg_done})) else $error("status read");
    role_hold_a: assert property (up_cnt >= 10 |-> $stable(is_sys_ctrl)) else $error("role moved");
endmodule // vsc_chk
bind vsc_top vsc_chk #(.CMOS_CLR_CYC(CMOS_CLR_CYC)) i_chk (.mclk, .rst_n, .bus_grant, .is_sys_ctrl,
    .sysclk_out, .clk10_oe, .ext_term_on, .term50_en, .cmos_clear, .cmos_clear_sel, .rd, .addr,
    .rdata, .cfg_done, .vxi_ready);

// >>> vsc_top_tb.sv
// Self-checking bench for the slot-zero role and load block
`timescale 1ns/1ps
module vsc_top_tb;
    logic mclk = 0, rst_n = 0, ce = 1, slot0_detect = 0, power_on_self_config = 1;
    logic user_half_sel = 1, ext_clk_sel = 0, clk10_route_en = 0, term50_en = 0;
    logic cmos_clear_sel = 0, sysrst_n = 0, wr = 0, rd = 0, mem_wr = 0, sc, pc, pk;
    logic [1:0] role_sel = 0;
    logic [3:0] addr = 0, req_set = 0, q, bus_req, bus_grant, host_cfg;
    logic [4:0] mem_waddr = 0;
    logic [15:0] wdata = 0, mem_wdata = 0, rdata, wf, wu, d;
    logic [11:0] bp_cfg;
    logic sysclk_out, sysclk_oe, clk10_in, ext_clk_in, clk10_out, clk10_oe, ext_clk_conn_oe;
    logic external_clock_connector, ext_term_on, cmos_clear, is_sys_ctrl, cfg_done, vxi_ready, rm_timeout;
    int n_fail = 0, check_count = 0, seed = 40409, k, nc, nk, lvl;
    always #5 mclk = ~mclk;
    vsc_top #(.RM_READY_CYC(200), .CMOS_CLR_CYC(50)) i_dut (.mclk, .rst_n, .ce, .role_sel,
        .slot0_detect, .power_on_self_config, .user_half_sel, .ext_clk_sel, .clk10_route_en,
        .term50_en, .cmos_clear_sel, .sysrst_n, .bus_req, .bus_grant, .sysclk_out, .sysclk_oe,
        .clk10_in, .ext_clk_in, .clk10_out, .clk10_oe, .external_clock_connector, .ext_clk_conn_oe,
        .ext_term_on, .cmos_clear, .is_sys_ctrl, .cfg_done, .vxi_ready, .rm_timeout, .addr, .wdata,
        .wr, .rd, .rdata, .host_cfg, .bp_cfg, .mem_wr, .mem_waddr, .mem_wdata);
    vsc_far i_far (.mclk, .rst_n, .req_set, .bus_grant, .bus_req, .ext_clk_in, .clk10_in);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic need(input logic c);
        if (c !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED %0t: wait ran out", $time);
            summarize();
        end
    endtask
    task automatic boot(input logic [1:0] r, input logic s0, p, x);
        @(posedge mclk);
        rst_n <= 0;
        sysrst_n <= 0;
        role_sel <= r;
        slot0_detect <= s0;
        power_on_self_config <= p;
        user_half_sel <= 1'($random(seed));
        ext_clk_sel <= x;
        repeat (2) @(posedge mclk);
        rst_n <= 1;
        repeat (10) @(posedge mclk);
        sysrst_n <= 1;
        @(negedge mclk);
    endtask
    task automatic mem_put(input logic [4:0] a, input logic [15:0] v);
        @(posedge mclk);
        mem_wr <= 1;
        mem_waddr <= a;
        mem_wdata <= v;
        @(posedge mclk);
        mem_wr <= 0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge mclk);
        rd <= 1;
        addr <= a;
        @(posedge mclk);
        rd <= 0;
        @(negedge mclk);
        d = rdata;
    endtask
    task automatic count(input int n);
        nc = 0;
        nk = 0;
        pc = sysclk_out;
        pk = clk10_out;
        repeat (n) begin
            @(negedge mclk);
            nc += (sysclk_out !== pc);
            nk += (clk10_out !== pk);
            pc = sysclk_out;
            pk = clk10_out;
        end
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1;
        wf = $random(seed);
        wu = $random(seed);
        mem_put(5'h01, wf);
        mem_put(5'h11, wu);
        for (int i = 0; i < 4; i++) begin
            sc = (i == 1 || i == 3);
            boot(i == 3 ? 2'h2 : {1'b0, i == 2}, i == 1 || i == 2, 1'b1, 1'b0);
            for (k = 0; k < 100 && cfg_done !== 1'b1; k++)
                @(negedge mclk);
            need(cfg_done);
            chk(is_sys_ctrl, sc);
            chk({sysclk_oe, clk10_oe}, {sc, sc});
            chk({bp_cfg, host_cfg}, user_half_sel ? wu : wf);
            rd_reg(4'h3);
            chk(d[2:0], {1'b1, user_half_sel, 1'b1});
            for (k = 0; k < 250 && vxi_ready !== 1'b1; k++)
                @(negedge mclk);
            need(vxi_ready);
            chk(rm_timeout, 0);
            count(60);
            if (sc)
                chk({nc[7:0], nk[7:0]}, {8'd20, 8'd12});
            @(posedge mclk);
            q = sc ? 4'($random(seed)) | 4'h1 : 4'hf;
            req_set <= q;
            @(posedge mclk);
            req_set <= 4'h0;
            for (lvl = 3; lvl >= 0; lvl--)
                if (sc && q[lvl]) begin
                    for (k = 0; k < 40 && bus_grant[lvl] !== 1'b1; k++)
                        @(negedge mclk);
                    need(bus_grant[lvl]);
                    chk({bus_grant, bus_req >> (lvl + 1)}, {4'h1 << lvl, 4'h0});
                end
            count(20);
            chk(bus_grant, 4'h0);
            @(posedge mclk);
            role_sel <= 2'h1;
            slot0_detect <= ~slot0_detect;
            repeat (10) @(negedge mclk);
            chk(is_sys_ctrl, sc);
        end
        @(posedge mclk);
        term50_en <= 1;
        clk10_route_en <= 1;
        boot(2'h2, 1'b0, 1'b1, 1'b1);
        count(160);
        chk(nk >= 19 && nk <= 21, 1);
        chk({ext_term_on, ext_clk_conn_oe}, 2'b10);
        boot(2'h2, 1'b0, 1'b1, 1'b0);
        chk(ext_term_on, 0);
        chk(ext_clk_conn_oe, 1);
        @(negedge mclk);
        pk = clk10_out;
        @(negedge mclk);
        chk(external_clock_connector, pk);
        boot(2'h0, 1'b1, 1'b0, 1'b0);
        repeat (210) @(negedge mclk);
        chk({cfg_done, vxi_ready, rm_timeout}, 3'b001);
        rd_reg(4'h9);
        chk(d, 0);
        @(posedge mclk);
        cmos_clear_sel <= 1;
        repeat (20) @(posedge mclk);
        cmos_clear_sel <= 0;
        repeat (10) @(negedge mclk);
        chk(cmos_clear, 0);
        @(posedge mclk);
        cmos_clear_sel <= 1;
        repeat (60) @(negedge mclk);
        chk(cmos_clear, 1);
        @(posedge mclk);
        cmos_clear_sel <= 0;
        repeat (5) @(negedge mclk);
        chk(cmos_clear, 0);
        summarize();
    end
endmodule // vsc_top_tb
